// ===== core/clf_btn_cond.sv
`timescale 1ns/1ps
module clf_btn_cond #(
   parameter logic [31:0] DEB_CYC  = clf_pkg::DEB_CYC,
   parameter logic [31:0] HOLD_CYC = clf_pkg::HOLD_CYC,
   parameter logic [31:0] RPT_CYC  = clf_pkg::RPT_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic btn_n,
   clf_btn_if.src    bus
);
   logic        s1_q, s2_q;   // pin synchroniser, pressed high
   logic        stab_q;       // debounced level
   logic [31:0] deb_q;        // debounce counter
   logic [31:0] hold_q;       // hold / repeat counter
   logic        rep_q;        // repeating phase reached
   logic        press_q, step_q;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= ~btn_n;
         s2_q <= s1_q;
      end
   end

   // level must hold steady a full debounce time
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stab_q <= 1'b0;
         deb_q  <= 32'h0;
      end else if (s2_q == stab_q) begin
         deb_q <= 32'h0;
      end else if (deb_q >= DEB_CYC - 32'h1) begin
         stab_q <= s2_q;
         deb_q  <= 32'h0;
      end else begin
         deb_q <= deb_q + 32'h1;
      end
   end

   // press pulse, then repeat pulses while held
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hold_q  <= 32'h0;
         rep_q   <= 1'b0;
         press_q <= 1'b0;
         step_q  <= 1'b0;
      end else begin
         press_q <= 1'b0;
         step_q  <= 1'b0;
         if (!stab_q) begin
            hold_q <= 32'h0;
            rep_q  <= 1'b0;
         end else if (hold_q == 32'h0 && !rep_q) begin
            // first cycle of a press
            press_q <= 1'b1;
            step_q  <= 1'b1;
            hold_q  <= 32'h1;
         end else if (hold_q >= (rep_q ? RPT_CYC : HOLD_CYC) - 32'h1) begin
            // held long enough: emit a repeat step
            step_q <= 1'b1;
            rep_q  <= 1'b1;
            hold_q <= 32'h1;
         end else begin
            hold_q <= hold_q + 32'h1;
         end
      end
   end

   assign bus.press = press_q;
   assign bus.step  = step_q;
endmodule

// ===== core/clf_btn_if.sv
`timescale 1ns/1ps
interface clf_btn_if;
   logic press;  // one-cycle pulse on a clean press
   logic step;   // press pulse plus auto-repeat pulses while held
   modport src (output press, output step);
   modport dst (input press, input step);
endinterface

// ===== core/clf_fill_ctrl.sv
`timescale 1ns/1ps
// Function
// - classify each thermistor as liquid or vapor
// - confirmed trigger exposure opens the fill valve
// - fill runs until fill-end probe immersed
// - top-off button fills to upper level
// - stop button ends any fill immediately
// - alarm outputs on any out-of-limit condition
// - log lid, valve and relay events
// - records carry date, time, level, temp, events
// - thermistor roles reassignable from the menu
// - menu, up, down, enter, back navigation
// - edit value steps per press, fast repeat when held
// - lock mark and scroll arrows per choice
// - monitoring continues while menu is open
// - 30 s idle returns to main screen
// - view-only mode rejects edits with lock
module clf_fill_ctrl #(
   parameter logic [31:0] CONFIRM_CYC = clf_pkg::CONFIRM_CYC,
   parameter logic [31:0] MENU_TO_CYC = clf_pkg::MENU_TO_CYC,
   parameter logic [31:0] REC_CYC     = clf_pkg::REC_CYC,
   parameter logic [31:0] DEB_CYC     = clf_pkg::DEB_CYC,
   parameter logic [31:0] HOLD_CYC    = clf_pkg::HOLD_CYC,
   parameter logic [31:0] RPT_CYC     = clf_pkg::RPT_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [63:0] sens_code,
   input  wire logic [6:0]  btn_n,
   input  wire logic        lid_open,
   input  wire logic        view_only,
   input  wire logic        temp_alarm,
   input  wire logic [15:0] rtc_date,
   input  wire logic [16:0] rtc_time,
   input  wire logic [11:0] temp_val,
   output logic             valve_q,
   output logic             alarm_aud_q,
   output logic             alarm_vis_q,
   output logic             relay_q,
   output logic             ev_valid_q,
   output logic [3:0]       ev_code_q,
   output logic             rec_valid_q,
   output logic [15:0]      rec_date_q,
   output logic [16:0]      rec_time_q,
   output logic [3:0]       rec_level_q,
   output logic [11:0]      rec_temp_q,
   output logic [3:0]       rec_event_q,
   output logic [8:0]       rec_err_q,
   output logic             menu_on_q,
   output logic             menu_edit_q,
   output logic [1:0]       menu_cur_q,
   output logic [2:0]       edit_val_q,
   output logic             item_lock_q,
   output logic             scroll_up_q,
   output logic             scroll_dn_q,
   output logic             lock_flash_q
);
   clf_btn_if         btn [clf_pkg::BTN_N] ();  // conditioned buttons
   logic [63:0]       sens_s1_q, sens_s2_q;     // probe code sync
   logic [1:0]        lid_s_q, view_s_q;         // two-flop sync pairs
   logic [7:0]        imm_q, err_q;             // per-thermistor class
   logic [2:0]        start_sel_q, stop_sel_q;  // thermistor roles
   logic              start_imm_q;              // previous trigger state
   clf_pkg::clf_fill_t fill_q;
   clf_pkg::clf_menu_t menu_q;
   logic [31:0]       conf_q, idle_q, rec_q;    // timers
   logic              lid_q, valve_pv_q, relay_pv_q;
   logic [5:0]        ev_pend_q, ev_set;
   logic              start_imm, stop_imm, any_err;
   logic [1:0]        prime_q;                  // sync pipeline filled

   // one conditioner per button
   genvar gi;
   for (gi = 0; gi < clf_pkg::BTN_N; gi++) begin : g_btn
      clf_btn_cond #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC),
                     .RPT_CYC(RPT_CYC)) u_cond (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .btn_n   (btn_n[gi]),
         .bus     (btn[gi])
      );
   end

   // pin synchronisers; stage one feeds stage two only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sens_s1_q <= 64'h0;
         sens_s2_q <= 64'h0;
         lid_s_q   <= 2'h0;
         view_s_q  <= 2'h0;
         prime_q   <= 2'h0;
      end else begin
         prime_q   <= {prime_q[0], 1'b1};
         sens_s1_q <= sens_code;
         sens_s2_q <= sens_s1_q;
         lid_s_q   <= {lid_s_q[0], lid_open};
         view_s_q  <= {view_s_q[0], view_only};
      end
   end

   // resistance code to liquid/vapor and fault flags
   // reset codes read as shorted sensors: hold off until real codes
   // arrive, else every power-up raises a false alarm and relay event
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         imm_q <= 8'h0;
         err_q <= 8'h0;
      end else if (prime_q[1]) begin
         for (int i = 0; i < clf_pkg::SENS_N; i++) begin
            imm_q[i] <= sens_s2_q[i*8 +: 8] >= clf_pkg::IMM_THR;
            err_q[i] <= sens_s2_q[i*8 +: 8] == clf_pkg::OPEN_CODE ||
                        sens_s2_q[i*8 +: 8] == clf_pkg::SHORT_CODE;
         end
      end
   end

   assign start_imm = imm_q[start_sel_q];
   assign stop_imm  = imm_q[stop_sel_q];
   assign any_err   = (|err_q) | temp_alarm;

   // fill sequencer; never looks at menu state, so menus cannot stall it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fill_q      <= clf_pkg::F_IDLE;
         valve_q     <= 1'b0;
         conf_q      <= 32'h0;
         start_imm_q <= 1'b0;
      end else begin
         start_imm_q <= start_imm;
         conf_q      <= 32'h0;
         case (fill_q)
            clf_pkg::F_IDLE, clf_pkg::F_CONFIRM: begin
               if (btn[clf_pkg::B_FILL].press && !stop_imm &&
                   !btn[clf_pkg::B_STOP].press) begin
                  fill_q  <= clf_pkg::F_MAN;
                  valve_q <= 1'b1;
               end else if (fill_q == clf_pkg::F_IDLE) begin
                  // only an immersed-to-exposed change arms a start
                  if (start_imm_q && !start_imm)
                     fill_q <= clf_pkg::F_CONFIRM;
               end else if (start_imm) begin
                  fill_q <= clf_pkg::F_IDLE;
               end else if (conf_q >= CONFIRM_CYC - 32'h1) begin
                  fill_q  <= clf_pkg::F_AUTO;
                  valve_q <= 1'b1;
               end else begin
                  conf_q <= conf_q + 32'h1;
               end
            end
            clf_pkg::F_AUTO, clf_pkg::F_MAN: begin
               // stop button and fill-end probe end both kinds alike
               if (btn[clf_pkg::B_STOP].press || stop_imm) begin
                  fill_q  <= clf_pkg::F_IDLE;
                  valve_q <= 1'b0;
               end
            end
            default: begin
               fill_q  <= clf_pkg::F_IDLE;
               valve_q <= 1'b0;
            end
         endcase
      end
   end

   // alarm indications track the condition set
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alarm_aud_q <= 1'b0;
         alarm_vis_q <= 1'b0;
         relay_q     <= 1'b0;
      end else begin
         alarm_aud_q <= any_err;
         alarm_vis_q <= any_err;
         relay_q     <= any_err;
      end
   end

   // edge detects feeding the event queue
   always_comb begin
      ev_set    = 6'h0;
      ev_set[0] = lid_s_q[1] & ~lid_q;
      ev_set[1] = ~lid_s_q[1] & lid_q;
      ev_set[2] = valve_q & ~valve_pv_q;
      ev_set[3] = ~valve_q & valve_pv_q;
      ev_set[4] = relay_q & ~relay_pv_q;
      ev_set[5] = ~relay_q & relay_pv_q;
   end

   // pending events drain one per cycle; a new set beats the drain
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lid_q      <= 1'b0;
         valve_pv_q <= 1'b0;
         relay_pv_q <= 1'b0;
         ev_pend_q  <= 6'h0;
         ev_valid_q <= 1'b0;
         ev_code_q  <= clf_pkg::EV_NONE;
      end else begin
         lid_q      <= lid_s_q[1];
         valve_pv_q <= valve_q;
         relay_pv_q <= relay_q;
         ev_valid_q <= 1'b0;
         ev_code_q  <= clf_pkg::EV_NONE;
         ev_pend_q  <= ev_pend_q | ev_set;
         for (int i = clf_pkg::EV_N - 1; i >= 0; i--) begin
            if (ev_pend_q[i]) begin
               ev_valid_q   <= 1'b1;
               ev_code_q    <= 4'(i + 1);
               ev_pend_q    <= (ev_pend_q & ~(6'h1 << i)) | ev_set;
            end
         end
      end
   end

   // data record on each event and on the periodic tick
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rec_q       <= 32'h0;
         rec_valid_q <= 1'b0;
         rec_date_q  <= 16'h0;
         rec_time_q  <= 17'h0;
         rec_level_q <= 4'h0;
         rec_temp_q  <= 12'h0;
         rec_event_q <= 4'h0;
         rec_err_q   <= 9'h0;
      end else begin
         rec_q       <= (rec_q >= REC_CYC - 32'h1) ? 32'h0 : rec_q + 32'h1;
         rec_valid_q <= ev_valid_q || rec_q >= REC_CYC - 32'h1;
         rec_date_q  <= rtc_date;
         rec_time_q  <= rtc_time;
         rec_level_q <= 4'($countones(imm_q));
         rec_temp_q  <= temp_val;
         rec_event_q <= ev_code_q;
         rec_err_q   <= {temp_alarm, err_q};
      end
   end

   // menu navigation, editing and inactivity timeout
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         menu_q       <= clf_pkg::M_MAIN;
         menu_cur_q   <= clf_pkg::MI_START;
         edit_val_q   <= 3'h0;
         idle_q       <= 32'h0;
         lock_flash_q <= 1'b0;
         start_sel_q  <= clf_pkg::START_RST;
         stop_sel_q   <= clf_pkg::STOP_RST;
      end else begin
         lock_flash_q <= 1'b0;
         idle_q <= (menu_q == clf_pkg::M_MAIN ||
                    (|{btn[0].step, btn[1].step, btn[2].step, btn[3].step,
                       btn[4].step, btn[5].step, btn[6].step}))
                   ? 32'h0 : idle_q + 32'h1;
         if (btn[clf_pkg::B_MENU].press) begin
            // menu key toggles in and out from any level
            menu_q <= (menu_q == clf_pkg::M_MAIN) ? clf_pkg::M_BROWSE
                                                  : clf_pkg::M_MAIN;
            menu_cur_q <= clf_pkg::MI_START;
         end else if (menu_q != clf_pkg::M_MAIN &&
                      idle_q >= MENU_TO_CYC - 32'h1) begin
            menu_q <= clf_pkg::M_MAIN;
         end else begin
            case (menu_q)
               clf_pkg::M_BROWSE: begin
                  if (btn[clf_pkg::B_DOWN].press &&
                      menu_cur_q < clf_pkg::MI_LAST)
                     menu_cur_q <= menu_cur_q + 2'h1;
                  else if (btn[clf_pkg::B_UP].press && menu_cur_q != 2'h0)
                     menu_cur_q <= menu_cur_q - 2'h1;
                  else if (btn[clf_pkg::B_BACK].press)
                     menu_q <= clf_pkg::M_MAIN;
                  else if (btn[clf_pkg::B_ENTER].press) begin
                     if (item_lock_q)
                        lock_flash_q <= 1'b1;
                     else begin
                        menu_q     <= clf_pkg::M_EDIT;
                        edit_val_q <= (menu_cur_q == clf_pkg::MI_START)
                                      ? start_sel_q : stop_sel_q;
                     end
                  end
               end
               clf_pkg::M_EDIT: begin
                  if (btn[clf_pkg::B_UP].step && edit_val_q < clf_pkg::SEL_MAX)
                     edit_val_q <= edit_val_q + 3'h1;
                  else if (btn[clf_pkg::B_DOWN].step && edit_val_q != 3'h0)
                     edit_val_q <= edit_val_q - 3'h1;
                  else if (btn[clf_pkg::B_BACK].press)
                     menu_q <= clf_pkg::M_BROWSE;  // discard edit
                  else if (btn[clf_pkg::B_ENTER].press) begin
                     menu_q <= clf_pkg::M_BROWSE;
                     if (menu_cur_q == clf_pkg::MI_START)
                        start_sel_q <= edit_val_q;
                     else
                        stop_sel_q <= edit_val_q;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // display indicators; lag the cursor by one cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         menu_on_q   <= 1'b0;
         menu_edit_q <= 1'b0;
         item_lock_q <= 1'b1;
         scroll_up_q <= 1'b0;
         scroll_dn_q <= 1'b0;
      end else begin
         menu_on_q   <= menu_q != clf_pkg::M_MAIN;
         menu_edit_q <= menu_q == clf_pkg::M_EDIT;
         item_lock_q <= view_s_q[1] ||
                        menu_cur_q == clf_pkg::MI_INFO;
         scroll_up_q <= menu_cur_q != 2'h0;
         scroll_dn_q <= menu_cur_q < clf_pkg::MI_LAST;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence seq_auto_open;
      ##1 (valve_q && fill_q == clf_pkg::F_AUTO);
   endsequence
   sequence seq_closed;
      ##1 (!valve_q && fill_q == clf_pkg::F_IDLE);
   endsequence

   AST_AUTO_OPEN: assert property (
      fill_q == clf_pkg::F_CONFIRM && !start_imm && !btn[0].press &&
      conf_q == CONFIRM_CYC - 32'h1 |-> seq_auto_open)
      else $error("auto fill did not open valve");
   AST_CANCEL: assert property (
      fill_q == clf_pkg::F_CONFIRM && start_imm && !btn[0].press
      |=> fill_q == clf_pkg::F_IDLE && !valve_q)
      else $error("re-immersion did not cancel start");
   AST_FILL_END: assert property (
      valve_q && stop_imm |-> seq_closed)
      else $error("fill did not end on fill-end probe");
   AST_STOP: assert property (
      valve_q && btn[clf_pkg::B_STOP].press |-> seq_closed)
      else $error("stop press left valve open");
   AST_TOPOFF: assert property (
      fill_q == clf_pkg::F_IDLE && btn[0].press && !btn[1].press && !stop_imm
      |=> valve_q && fill_q == clf_pkg::F_MAN)
      else $error("top-off press did not start fill");
   AST_ALARM: assert property (
      any_err |=> alarm_aud_q && alarm_vis_q)
      else $error("alarm not raised");
   AST_VALVE_EVENT: assert property (
      $rose(valve_q) |-> ##[1:7] (ev_valid_q &&
                                 ev_code_q == clf_pkg::EV_VLV_OPEN))
      else $error("valve open not logged");
   AST_TIMEOUT: assert property (
      menu_q != clf_pkg::M_MAIN && idle_q == MENU_TO_CYC - 32'h1 &&
      !btn[clf_pkg::B_MENU].press |=> menu_q == clf_pkg::M_MAIN)
      else $error("menu did not time out");
   AST_VIEW_ONLY: assert property (
      menu_q == clf_pkg::M_BROWSE && item_lock_q && !btn[2].press &&
      !btn[3].press && !btn[4].press && !btn[6].press &&
      btn[clf_pkg::B_ENTER].press && idle_q < MENU_TO_CYC - 32'h1
      |=> lock_flash_q && menu_q == clf_pkg::M_BROWSE)
      else $error("locked item entered edit");
   AST_COMMIT: assert property (
      menu_q == clf_pkg::M_EDIT && btn[5].press && !btn[2].press &&
      !btn[3].step && !btn[4].step && !btn[6].press &&
      menu_cur_q == clf_pkg::MI_START && idle_q < MENU_TO_CYC - 32'h1
      |=> start_sel_q == $past(edit_val_q))
      else $error("role not committed");
endmodule

// ===== core/clf_pkg.sv
package clf_pkg;
   // clock and sensor geometry
   localparam int         CLK_HZ     = 100_000_000;  // system clock rate
   localparam int         SENS_N     = 8;            // thermistors on probe
   localparam int         SENS_W     = 8;            // resistance code width
   localparam int         SEL_W      = 3;            // thermistor index width
   localparam int         LVL_W      = 4;            // immersed count width
   // resistance code interpretation
   localparam logic [7:0] IMM_THR    = 8'h80;        // at or above: in liquid
   localparam logic [7:0] OPEN_CODE  = 8'hff;        // open sensor circuit
   localparam logic [7:0] SHORT_CODE = 8'h00;        // shorted sensor
   // timing, in their own units, and derived cycle counts
   localparam int          CONFIRM_MS  = 10_000;     // low-level confirm delay
   localparam int          MENU_TO_S   = 30;         // menu inactivity limit
   localparam int          DEB_MS      = 20;         // button debounce
   localparam int          HOLD_MS     = 500;        // hold before repeat
   localparam int          RPT_MS      = 100;        // repeat interval
   localparam int          REC_MS      = 10_000;     // data record interval
   localparam logic [31:0] CONFIRM_CYC = 32'(CONFIRM_MS * (CLK_HZ / 1000));
   localparam logic [31:0] MENU_TO_CYC =
      32'(64'(MENU_TO_S) * 64'(CLK_HZ));
   localparam logic [31:0] DEB_CYC     = 32'(DEB_MS * (CLK_HZ / 1000));
   localparam logic [31:0] HOLD_CYC    = 32'(HOLD_MS * (CLK_HZ / 1000));
   localparam logic [31:0] RPT_CYC     = 32'(RPT_MS * (CLK_HZ / 1000));
   localparam logic [31:0] REC_CYC     = 32'(REC_MS * (CLK_HZ / 1000));
   // front-panel button indices
   localparam int         BTN_N   = 7;
   localparam int         B_FILL  = 0;
   localparam int         B_STOP  = 1;
   localparam int         B_MENU  = 2;
   localparam int         B_DOWN  = 3;
   localparam int         B_UP    = 4;
   localparam int         B_ENTER = 5;
   localparam int         B_BACK  = 6;
   // menu items and reset roles
   localparam logic [1:0] MI_START  = 2'h0;          // start-fill sensor role
   localparam logic [1:0] MI_STOP   = 2'h1;          // stop-fill sensor role
   localparam logic [1:0] MI_INFO   = 2'h2;          // info page, always locked
   localparam logic [1:0] MI_LAST   = 2'h2;
   localparam logic [2:0] START_RST = 3'h2;
   localparam logic [2:0] STOP_RST  = 3'h5;
   localparam logic [2:0] SEL_MAX   = 3'h7;
   // system event codes
   localparam int         EV_N         = 6;
   localparam logic [3:0] EV_NONE      = 4'h0;
   localparam logic [3:0] EV_LID_OPEN  = 4'h1;
   localparam logic [3:0] EV_LID_CLOSE = 4'h2;
   localparam logic [3:0] EV_VLV_OPEN  = 4'h3;
   localparam logic [3:0] EV_VLV_CLOSE = 4'h4;
   localparam logic [3:0] EV_RLY_ON    = 4'h5;
   localparam logic [3:0] EV_RLY_OFF   = 4'h6;
   // state types
   typedef enum logic [1:0] {F_IDLE, F_CONFIRM, F_AUTO, F_MAN} clf_fill_t;
   typedef enum logic [1:0] {M_MAIN, M_BROWSE, M_EDIT} clf_menu_t;
endpackage

// ===== tb/clf_probe_model.sv
`timescale 1ns/1ps
// probe stand-in: sensors counted from the bottom of the tube
module clf_probe_model (
   input  wire logic [3:0]  level,
   input  wire logic        fault,
   output logic      [63:0] sens_code
);
   // liquid reads high and vapor reads low, clear of both fault codes
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         sens_code[8*i +: 8] = (i < level) ? 8'hc0 : 8'h40;
      end
      // an open circuit on the top sensor
      if (fault) begin
         sens_code[63:56] = 8'hff;
      end
   end
endmodule

// ===== tb/cryogenic_level_fill_control_tb.sv
`timescale 1ns/1ps
module cryogenic_level_fill_control_tb;
   logic        clk_sys    = 1'b0;
   logic        rst_n      = 1'b0;
   logic [3:0]  level      = 4'h4;  // sensors below the liquid
   logic        fault      = 1'b0;
   logic [6:0]  btn_n      = 7'h7f; // all released
   logic        lid_open   = 1'b0;
   logic        view_only  = 1'b0;
   logic        temp_alarm = 1'b0;
   logic [63:0] sens_code;
   logic        valve_q, aud_q, vis_q, ev_v, rec_v, on_q, edit_q, flash_q;
   logic        lock_q, up_q, dn_q;
   logic [3:0]  ev_c;
   logic [8:0]  err_q;
   logic [1:0]  cur_q;
   logic [2:0]  val_q;
   logic [3:0]  last_ev   = 4'h0;  // latest event code seen
   logic [8:0]  last_err  = 9'h0;  // error field of latest record
   logic        relay;
   logic [3:0]  rec_lvl, rec_ev;
   logic [11:0] rec_tmp;
   logic [3:0]  last_lvl  = 4'h0;  // level field of latest record
   logic [3:0]  last_rev  = 4'h0;  // event field of latest event record
   logic [11:0] last_temp = 12'h0; // temperature of latest record
   logic        flash_seen = 1'b0;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   always #5 clk_sys = ~clk_sys;
   clf_probe_model clf_probe_model_i (.level(level), .fault(fault),
      .sens_code(sens_code));
   // short counts keep the run brief; expectations use the same figures
   clf_fill_ctrl #(.CONFIRM_CYC(32'd20), .MENU_TO_CYC(32'd200),
      .REC_CYC(32'd500), .DEB_CYC(32'd4), .HOLD_CYC(32'd40),
      .RPT_CYC(32'd10)) clf_fill_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .sens_code(sens_code), .btn_n(btn_n), .lid_open(lid_open),
      .view_only(view_only), .temp_alarm(temp_alarm),
      .rtc_date(16'h1234), .rtc_time(17'h0abcd), .temp_val(12'h0c4),
      .valve_q(valve_q), .alarm_aud_q(aud_q), .alarm_vis_q(vis_q),
      .relay_q(relay), .ev_valid_q(ev_v), .ev_code_q(ev_c),
      .rec_valid_q(rec_v), .rec_date_q(), .rec_time_q(),
      .rec_level_q(rec_lvl), .rec_temp_q(rec_tmp),
      .rec_event_q(rec_ev), .rec_err_q(err_q), .menu_on_q(on_q),
      .menu_edit_q(edit_q), .menu_cur_q(cur_q), .edit_val_q(val_q),
      .item_lock_q(lock_q), .scroll_up_q(up_q), .scroll_dn_q(dn_q),
      .lock_flash_q(flash_q));
   // pulses are caught here so a scenario may look later
   always @(posedge clk_sys) begin
      if (ev_v === 1'b1) last_ev <= ev_c;
      if (rec_v === 1'b1) begin
         last_err  <= err_q;
         last_lvl  <= rec_lvl;
         last_temp <= rec_tmp;
         if (rec_ev !== 4'h0) last_rev <= rec_ev;  // periodic rows carry none
      end
      if (flash_q === 1'b1) flash_seen <= 1'b1;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // held past sync plus debounce, then released as long
   task automatic press(input int b);
      btn_n[b] = 1'b0;
      tick(12);
      btn_n[b] = 1'b1;
      tick(12);
   endtask
   // bounded wait on the valve, then judged
   task automatic wait_valve(input logic v);
      for (int i = 0; i < 60 && valve_q !== v; i++) tick(1);
      chk(valve_q, v);
   endtask
   task automatic t_auto;
      level = 4'h2;      // start sensor now in vapor
      tick(10);
      chk(valve_q, 1'b0);
      level = 4'h3;      // back in liquid before the delay ends
      tick(40);
      chk(valve_q, 1'b0);
      level = 4'h2;
      wait_valve(1'b1);
      tick(8);
      chk(last_ev, 4'h3);
      chk(last_rev, 4'h3);
      chk(last_lvl, 4'h2);
      chk(last_temp, 12'h0c4);
      level = 4'h6;      // stop sensor reached
      wait_valve(1'b0);
      tick(8);
      chk(last_ev, 4'h4);
      chk(last_rev, 4'h4);
      chk(last_lvl, 4'h6);
      $display("done auto fill");
   endtask
   task automatic t_manual;
      press(clf_pkg::B_FILL);
      chk(valve_q, 1'b0);
      level = 4'h4;
      press(clf_pkg::B_FILL);
      wait_valve(1'b1);
      press(clf_pkg::B_STOP);
      wait_valve(1'b0);
      press(clf_pkg::B_FILL);
      wait_valve(1'b1);
      level = 4'h6;
      wait_valve(1'b0);
      $display("done manual fill");
   endtask
   // alarms and logging while the menu stays open
   task automatic t_alarm;
      press(clf_pkg::B_MENU);
      temp_alarm = 1'b1;
      fault = 1'b1;      // overlap keeps the relay from dropping out
      tick(6);
      chk(aud_q, 1'b1);
      chk(vis_q, 1'b1);
      chk(relay, 1'b1);
      temp_alarm = 1'b0;
      tick(6);
      lid_open = 1'b1;
      tick(12);
      chk(last_ev, 4'h1);
      chk(last_err[7], 1'b1);
      fault = 1'b0;
      press(clf_pkg::B_MENU);
      chk(on_q, 1'b0);
      $display("done alarms");
   endtask
   task automatic t_view;
      view_only = 1'b1;
      press(clf_pkg::B_MENU);
      chk(on_q, 1'b1);
      press(clf_pkg::B_DOWN);
      chk(cur_q, 2'h1);
      chk({up_q, dn_q}, 2'h3);
      press(clf_pkg::B_ENTER);
      chk(flash_seen, 1'b1);
      chk(edit_q, 1'b0);
      chk(lock_q, 1'b1);
      press(clf_pkg::B_BACK);
      chk(on_q, 1'b0);
      view_only = 1'b0;
      $display("done view only");
   endtask
   task automatic t_edit;
      press(clf_pkg::B_MENU);
      press(clf_pkg::B_ENTER);
      chk(edit_q, 1'b1);
      chk(val_q, 3'h2);
      btn_n[clf_pkg::B_UP] = 1'b0;  // held: repeats up to the clamp
      tick(150);
      btn_n[clf_pkg::B_UP] = 1'b1;
      tick(12);
      chk(val_q, 3'h7);
      press(clf_pkg::B_BACK);
      press(clf_pkg::B_ENTER);
      chk(val_q, 3'h2);
      press(clf_pkg::B_UP);
      chk(val_q, 3'h3);
      press(clf_pkg::B_ENTER);
      press(clf_pkg::B_ENTER);
      chk(val_q, 3'h3);
      tick(150);
      chk(on_q, 1'b1);
      tick(70);
      chk(on_q, 1'b0);
      $display("done menu edit");
   endtask
   task automatic wrap_up;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog far beyond the roughly one thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      tick(20);
      chk({valve_q, lock_q, cur_q}, 4'h4);
      rst_n = 1'b1;
      tick(20);
      t_auto();
      t_manual();
      t_alarm();
      t_view();
      t_edit();
      wrap_up();
   end
endmodule
